// [crf_defines.svh]
// constants for the core register file and status flags block
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH

// status register addresses and reset value
`define CRF_STATUS_IO     6'h3F
`define CRF_STATUS_DATA   16'h005F
`define CRF_STATUS_RESET  8'h00

// io space seen from data space
`define CRF_IO_DATA_OFS   16'h0020
`define CRF_GPR_LAST      16'h001F

// status bit positions
`define CRF_FLAG_I        7
`define CRF_FLAG_T        6
`define CRF_FLAG_H        5
`define CRF_FLAG_S        4
`define CRF_FLAG_V        3
`define CRF_FLAG_N        2
`define CRF_FLAG_Z        1
`define CRF_FLAG_C        0

// pointer pairs, low byte index
`define CRF_PTR_X         5'h1A
`define CRF_PTR_Y         5'h1C
`define CRF_PTR_Z         5'h1E

// multiply result pair
`define CRF_MUL_LO        5'h00
`define CRF_MUL_HI        5'h01

// widths
`define CRF_GPR_COUNT     32
`define CRF_IRQ_IDX_W     5

`endif

// [crf_pkg.sv]
// types shared by the register file and status flags block
`default_nettype none
`include "crf_defines.svh"

package crf_pkg;

   // operations issued by the execution logic
   typedef enum logic [4:0] {
      OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR,
      OP_COM, OP_NEG, OP_INC, OP_DEC, OP_LSR, OP_ROR, OP_ASR, OP_MOV,
      OP_MUL, OP_ADIW, OP_SBIW, OP_MOVW, OP_BIT_STORE, OP_BIT_LOAD,
      OP_SET_GATE, OP_CLEAR_GATE, OP_IRQ_RETURN, OP_CALL,
      OP_DATA_LOAD, OP_DATA_STORE, OP_IO_IN, OP_IO_OUT
   } crf_op_e;

   // address source of a data space access
   typedef enum logic [1:0] {ADDR_DIRECT, ADDR_X, ADDR_Y, ADDR_Z} crf_addr_e;

   // whole state of the core block
   typedef struct packed {
      logic [`CRF_GPR_COUNT-1:0][7:0] gpr;
      logic [7:0]                     status;
      logic                           holdOff;
      logic                           loadPending;
      logic [4:0]                     loadDst;
      logic                           memRead;
      logic                           memWrite;
      logic [15:0]                    memAddr;
      logic [7:0]                     memWdata;
      logic                           pushValid;
      logic [15:0]                    pushData;
      logic                           irqTake;
      logic [`CRF_IRQ_IDX_W-1:0]      irqIndex;
   } crf_state_s;

endpackage

`default_nettype wire

// [crf_alu_if.sv]
// operand and result bundle between core and arithmetic unit
`timescale 1ns/1ns
`default_nettype none

interface crf_alu_if;
   import crf_pkg::*;
   crf_op_e     op;         // operation
   logic [7:0]  opA;        // first 8-bit operand
   logic [7:0]  opB;        // second operand or constant
   logic [15:0] wordA;      // 16-bit operand
   logic [7:0]  flagsIn;    // current status
   logic [15:0] result;     // result, low byte for 8-bit ops
   logic [7:0]  flagsOut;   // updated status

   modport core (output op, opA, opB, wordA, flagsIn, input result, flagsOut);
   modport alu  (input op, opA, opB, wordA, flagsIn, output result, flagsOut);
endinterface

`default_nettype wire

// [crf_alu.sv]
// single cycle arithmetic unit with flag generation
`timescale 1ns/1ns
`default_nettype none
`include "crf_defines.svh"

module crf_alu (
   crf_alu_if.alu aluPort   // operands in, result and flags out
);
   import crf_pkg::*;

   logic [8:0]  sum;
   logic [7:0]  a;
   logic [7:0]  b;
   logic [7:0]  r;
   logic [15:0] w;
   logic [7:0]  mask;
   logic [7:0]  fresh;
   logic        cin;
   logic        c;
   logic        h;
   logic        v;
   logic        n;
   logic        z;
   logic        wide;

   assign a   = aluPort.opA;
   assign b   = aluPort.opB;
   assign cin = aluPort.flagsIn[`CRF_FLAG_C];

   // result and raw flags per operation
   always_comb begin
      sum  = 9'h000;
      r    = a;
      w    = 16'h0000;
      c    = cin;
      h    = aluPort.flagsIn[`CRF_FLAG_H];
      v    = 1'b0;
      z    = 1'b0;
      wide = 1'b0;
      mask = 8'h1E;
      unique case (aluPort.op)
         OP_ADD, OP_ADC: begin
            sum  = {1'b0, a} + {1'b0, b} + {8'h00, cin & (aluPort.op == OP_ADC)};
            r    = sum[7:0];
            c    = sum[8];
            h    = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
            v    = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
            mask = 8'h3F;
         end
         OP_SUB, OP_SBC: begin
            sum  = {1'b0, a} - {1'b0, b} - {8'h00, cin & (aluPort.op == OP_SBC)};
            r    = sum[7:0];
            c    = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
            h    = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            v    = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
            mask = 8'h3F;
         end
         OP_AND: r = a & b;
         OP_OR:  r = a | b;
         OP_EOR: r = a ^ b;
         OP_COM: begin
            r    = ~a;
            c    = 1'b1;
            mask = 8'h1F;
         end
         OP_NEG: begin
            r    = 8'h00 - a;
            c    = (r != 8'h00);
            h    = r[3] | a[3];
            v    = (r == 8'h80);
            mask = 8'h3F;
         end
         OP_INC: begin
            r = a + 8'h01;
            v = (r == 8'h80);
         end
         OP_DEC: begin
            r = a - 8'h01;
            v = (r == 8'h7F);
         end
         OP_LSR, OP_ROR, OP_ASR: begin
            r    = {(aluPort.op == OP_ROR) ? cin : (aluPort.op == OP_ASR) & a[7], a[7:1]};
            c    = a[0];
            v    = r[7] ^ a[0];
            mask = 8'h1F;
         end
         OP_MOV: mask = 8'h00;
         OP_MUL: begin
            wide = 1'b1;
            w    = {8'h00, a} * {8'h00, b};
            c    = w[15];
            mask = 8'h03;
         end
         OP_ADIW: begin
            wide = 1'b1;
            w    = aluPort.wordA + {8'h00, b};
            v    = ~aluPort.wordA[15] & w[15];
            c    = aluPort.wordA[15] & ~w[15];
            mask = 8'h1F;
         end
         OP_SBIW: begin
            wide = 1'b1;
            w    = aluPort.wordA - {8'h00, b};
            v    = aluPort.wordA[15] & ~w[15];
            c    = ~aluPort.wordA[15] & w[15];
            mask = 8'h1F;
         end
         OP_MOVW: begin
            wide = 1'b1;
            w    = aluPort.wordA;
            mask = 8'h00;
         end
         default: mask = 8'h00;
      endcase
      n = wide ? w[15] : r[7];
      z = wide ? (w == 16'h0000) : (r == 8'h00);
      // carry-chained subtract keeps zero only if it was already zero
      if (aluPort.op == OP_SBC) begin
         z = z & aluPort.flagsIn[`CRF_FLAG_Z];
      end
      fresh = {aluPort.flagsIn[7:6], h, n ^ v, v, n, z, c};
   end

   // merge only the flags the operation affects
   assign aluPort.result   = wide ? w : {8'h00, r};
   assign aluPort.flagsOut = (fresh & mask) | (aluPort.flagsIn & ~mask);

endmodule

`default_nettype wire

// [crf_irq_gate.sv]
// fixed priority pick among pending interrupt requests
`timescale 1ns/1ns
`default_nettype none
`include "crf_defines.svh"

module crf_irq_gate #(
   parameter int NUM_IRQ = 8
) (
   input  wire logic [NUM_IRQ-1:0]        lines,    // pending requests
   input  wire logic                      enable,   // taking allowed now
   output logic                           take,     // take one this cycle
   output logic [`CRF_IRQ_IDX_W-1:0]      index     // chosen request
);

   // lowest index wins, scan from the top down
   always_comb begin
      index = '0;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (lines[i]) begin
            index = `CRF_IRQ_IDX_W'(i);
         end
      end
      take = enable & (|lines);
   end

endmodule

`default_nettype wire

// [crf_core.sv]
// general purpose register file, status flags and interrupt gate of the core
//
// Behaviour
// - thirty-two byte registers; six also form three 16-bit pointers
// - the third pointer also addresses program memory tables
// - register or constant operations finish and write back in one cycle
// - every arithmetic or logic operation updates the status flags
// - status is neither saved on interrupt entry nor restored on return
// - status sits at io 0x3F and data 0x5F, resets to zero
// - io addresses plus 0x20 reach io space through data accesses
// - bit 7 gates all interrupts; clear means none taken
// - taking an interrupt clears the gate; interrupt return sets it
// - set-gate and clear-gate operations drive the gate directly
// - bit 6 copy bit: bit store loads it, bit load writes it back
// - bit 5 half carry from low nibble
// - bit 4 sign equals negative xor overflow
// - bit 3 two's complement overflow
// - bit 2 negative result
// - bit 1 zero result
// - bit 0 carry
// - four port schemes: 8r/8w, 2x8r/8w, 2x8r/16w, 16r/16w
// - registers at data 0x00-0x1F; pointers low byte first from 0x1A
// - pointer addresses inside the file reach the matching register
// - lower request index means higher priority
// - interrupt or call pushes the return program counter
// - after interrupt return one more instruction runs before any interrupt
`timescale 1ns/1ns
`default_nettype none
`include "crf_defines.svh"

module crf_core #(
   parameter int NUM_IRQ = 8
) (
   input  wire logic                        clk,             // core clock
   input  wire logic                        rst,             // async reset, high
   input  wire logic                        opValid,         // operation executes this cycle
   input  wire crf_pkg::crf_op_e            opCode,          // operation
   input  wire logic [4:0]                  dstSel,          // destination register
   input  wire logic [4:0]                  srcSel,          // source register
   input  wire logic [7:0]                  immData,         // immediate constant
   input  wire logic                        useImm,          // constant replaces source
   input  wire logic [2:0]                  bitSel,          // bit for copy ops
   input  wire crf_pkg::crf_addr_e          addrMode,        // direct or pointer address
   input  wire logic [15:0]                 dataAddr,        // direct or io address
   input  wire logic [15:0]                 programCounter,  // return address to push
   input  wire logic [NUM_IRQ-1:0]          irqLines,        // pending interrupt requests
   input  wire logic                        irqSlot,         // instruction boundary
   input  wire logic                        loadReturnValid, // external load data valid
   input  wire logic [7:0]                  loadReturnData,  // external load data
   output logic [7:0]                       statusFlags,     // status register
   output logic [15:0]                      ptrX,            // first pointer
   output logic [15:0]                      ptrY,            // second pointer
   output logic [15:0]                      tablePtr,        // third pointer
   output logic                             loadBusy,        // external load outstanding
   output logic                             memRead,         // external read pulse
   output logic                             memWrite,        // external write pulse
   output logic [15:0]                      memAddr,         // external data address
   output logic [7:0]                       memWdata,        // external write data
   output logic                             pushValid,       // stack push pulse
   output logic [15:0]                      pushData,        // pushed program counter
   output logic                             irqTake,         // interrupt taken pulse
   output logic [`CRF_IRQ_IDX_W-1:0]        irqIndex         // taken request
);
   import crf_pkg::*;

   crf_state_s                   stateReg;
   crf_state_s                   stateNext;
   logic [15:0]                  baseAddr;
   logic [15:0]                  accessAddr;
   logic                         irqEnable;
   logic                         irqGo;
   logic [`CRF_IRQ_IDX_W-1:0]    irqSel;
   logic [4:0]                   dstPair;

   crf_alu_if aluBus ();

   // read a register pair, low byte at the even index
   function automatic logic [15:0] pairOf(input logic [`CRF_GPR_COUNT-1:0][7:0] g,
                                          input logic [4:0] idx);
      pairOf = {g[{idx[4:1], 1'b1}], g[{idx[4:1], 1'b0}]};
   endfunction

   // data space address falls inside the register file
   function automatic logic inFile(input logic [15:0] addr);
      inFile = (addr <= `CRF_GPR_LAST);
   endfunction

   // data space address selects the status register
   function automatic logic isStatus(input logic [15:0] addr);
      isStatus = (addr == `CRF_STATUS_DATA);
   endfunction

   assign dstPair = {dstSel[4:1], 1'b0};

   // operand taps feeding the arithmetic unit
   assign aluBus.op      = opCode;
   assign aluBus.opA     = stateReg.gpr[dstSel];
   assign aluBus.opB     = useImm ? immData : stateReg.gpr[srcSel];
   assign aluBus.wordA   = pairOf(stateReg.gpr, (opCode == OP_MOVW) ? srcSel : dstSel);
   assign aluBus.flagsIn = stateReg.status;

   crf_alu uAlu (
      .aluPort (aluBus)
   );

   // address of a data or io access
   always_comb begin
      unique case (addrMode)
         ADDR_DIRECT: baseAddr = dataAddr;
         ADDR_X:      baseAddr = pairOf(stateReg.gpr, `CRF_PTR_X);
         ADDR_Y:      baseAddr = pairOf(stateReg.gpr, `CRF_PTR_Y);
         ADDR_Z:      baseAddr = pairOf(stateReg.gpr, `CRF_PTR_Z);
      endcase
   end

   // io instructions see the same space shifted into data addresses
   assign accessAddr = (opValid && (opCode == OP_IO_IN || opCode == OP_IO_OUT)) ?
                       ({10'h000, dataAddr[5:0]} + `CRF_IO_DATA_OFS) : baseAddr;

   // gate closed, hold-off after return, or a gate-clearing op blocks taking
   assign irqEnable = irqSlot & stateReg.status[`CRF_FLAG_I] & ~stateReg.holdOff
                      & ~(opValid & (opCode == OP_CLEAR_GATE || opCode == OP_CALL ||
                                     opCode == OP_IRQ_RETURN));

   crf_irq_gate #(
      .NUM_IRQ (NUM_IRQ)
   ) uIrq (
      .lines  (irqLines),
      .enable (irqEnable),
      .take   (irqGo),
      .index  (irqSel)
   );

   // next state: load return, then the operation, then interrupt entry
   always_comb begin
      stateNext           = stateReg;
      stateNext.memRead   = 1'b0;
      stateNext.memWrite  = 1'b0;
      stateNext.pushValid = 1'b0;
      stateNext.irqTake   = 1'b0;

      // external load data lands in the held destination
      if (stateReg.loadPending && loadReturnValid) begin
         stateNext.gpr[stateReg.loadDst] = loadReturnData;
         stateNext.loadPending           = 1'b0;
      end

      if (opValid) begin
         unique case (opCode)
            OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR, OP_COM,
            OP_NEG, OP_INC, OP_DEC, OP_LSR, OP_ROR, OP_ASR, OP_MOV: begin
               stateNext.gpr[dstSel] = aluBus.result[7:0];
               stateNext.status      = aluBus.flagsOut;
            end
            OP_MUL: begin
               stateNext.gpr[`CRF_MUL_LO] = aluBus.result[7:0];
               stateNext.gpr[`CRF_MUL_HI] = aluBus.result[15:8];
               stateNext.status           = aluBus.flagsOut;
            end
            OP_ADIW, OP_SBIW, OP_MOVW: begin
               stateNext.gpr[dstPair]        = aluBus.result[7:0];
               stateNext.gpr[dstPair + 5'h01] = aluBus.result[15:8];
               stateNext.status              = aluBus.flagsOut;
            end
            OP_BIT_STORE: begin
               stateNext.status[`CRF_FLAG_T] = stateReg.gpr[dstSel][bitSel];
            end
            OP_BIT_LOAD: begin
               stateNext.gpr[dstSel][bitSel] = stateReg.status[`CRF_FLAG_T];
            end
            OP_SET_GATE: begin
               stateNext.status[`CRF_FLAG_I] = 1'b1;
            end
            OP_CLEAR_GATE: begin
               stateNext.status[`CRF_FLAG_I] = 1'b0;
            end
            OP_IRQ_RETURN: begin
               // status flags other than the gate are left as software set them
               stateNext.status[`CRF_FLAG_I] = 1'b1;
               stateNext.holdOff             = 1'b1;
            end
            OP_CALL: begin
               stateNext.pushValid = 1'b1;
               stateNext.pushData  = programCounter;
            end
            OP_DATA_LOAD, OP_IO_IN: begin
               if (inFile(accessAddr)) begin
                  stateNext.gpr[dstSel] = stateReg.gpr[accessAddr[4:0]];
               end else if (isStatus(accessAddr)) begin
                  stateNext.gpr[dstSel] = stateReg.status;
               end else begin
                  stateNext.memRead     = 1'b1;
                  stateNext.memAddr     = accessAddr;
                  stateNext.loadPending = 1'b1;
                  stateNext.loadDst     = dstSel;
               end
            end
            OP_DATA_STORE, OP_IO_OUT: begin
               if (inFile(accessAddr)) begin
                  stateNext.gpr[accessAddr[4:0]] = stateReg.gpr[srcSel];
               end else if (isStatus(accessAddr)) begin
                  stateNext.status = stateReg.gpr[srcSel];
               end else begin
                  stateNext.memWrite = 1'b1;
                  stateNext.memAddr  = accessAddr;
                  stateNext.memWdata = stateReg.gpr[srcSel];
               end
            end
            OP_NOP: begin
            end
            default: begin
            end
         endcase
         // any completed instruction other than the return ends the hold-off
         if (opCode != OP_IRQ_RETURN) begin
            stateNext.holdOff = 1'b0;
         end
      end

      // interrupt entry pushes the return address, status is not saved
      if (irqGo) begin
         stateNext.status[`CRF_FLAG_I] = 1'b0;
         stateNext.irqTake             = 1'b1;
         stateNext.irqIndex            = irqSel;
         stateNext.pushValid           = 1'b1;
         stateNext.pushData            = programCounter;
      end
   end

   // state register, everything cleared at reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stateReg        <= '0;
         stateReg.status <= `CRF_STATUS_RESET;
      end else begin
         stateReg <= stateNext;
      end
   end

   // outputs straight from the state flops
   assign statusFlags = stateReg.status;
   assign ptrX        = pairOf(stateReg.gpr, `CRF_PTR_X);
   assign ptrY        = pairOf(stateReg.gpr, `CRF_PTR_Y);
   assign tablePtr    = pairOf(stateReg.gpr, `CRF_PTR_Z);
   assign loadBusy    = stateReg.loadPending;
   assign memRead     = stateReg.memRead;
   assign memWrite    = stateReg.memWrite;
   assign memAddr     = stateReg.memAddr;
   assign memWdata    = stateReg.memWdata;
   assign pushValid   = stateReg.pushValid;
   assign pushData    = stateReg.pushData;
   assign irqTake     = stateReg.irqTake;
   assign irqIndex    = stateReg.irqIndex;

endmodule

`default_nettype wire

// [crf_core_monitor.sv]
// port assertions for the core register file and status flags
`timescale 1ns/1ns
`default_nettype none
module crf_core_monitor (
   input wire logic             clk,         // clock
   input wire logic             rst,         // reset
   input wire logic             opValid,     // op strobe
   input wire crf_pkg::crf_op_e opCode,      // op code
   input wire logic [4:0]       dstSel,      // destination
   input wire logic [4:0]       srcSel,      // source
   input wire logic [7:0]       statusFlags, // status
   input wire logic [15:0]      ptrX,        // first pointer
   input wire logic [15:0]      tablePtr,    // third pointer
   input wire logic             pushValid,   // push pulse
   input wire logic             irqTake      // take pulse
);
   import crf_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // flags, gate and pair behaviour
   rst_clears_a: assert property ($fell(rst) |-> statusFlags == 8'h00 && tablePtr == 16'h0000)
      else $error("status not clear after reset");
   sign_xor_a: assert property (opValid && opCode inside {OP_ADD, OP_ADC}
      |=> statusFlags[4] == (statusFlags[2] ^ statusFlags[3])) else $error("sign flag wrong");
   gate_open_a: assert property (irqTake |-> $past(statusFlags[7]))
      else $error("take with gate closed");
   take_clears_a: assert property (irqTake |-> !statusFlags[7] && pushValid)
      else $error("take left gate open or no push");
   set_gate_a: assert property (opValid && opCode == OP_SET_GATE |=> statusFlags[7])
      else $error("gate not set");
   clear_gate_a: assert property (opValid && opCode == OP_CLEAR_GATE |=> !statusFlags[7] && !irqTake)
      else $error("gate not cleared");
   return_hold_a: assert property (opValid && opCode == OP_IRQ_RETURN
      |=> statusFlags[7] && !irqTake ##1 !irqTake) else $error("take too soon after return");
   pair_move_a: assert property (opValid && opCode == OP_MOVW && dstSel == 5'h1E && srcSel == 5'h1A
      |=> tablePtr == $past(ptrX)) else $error("pair move wrong");
endmodule
bind crf_core crf_core_monitor mon_u (.clk, .rst, .opValid, .opCode, .dstSel, .srcSel, .statusFlags, .ptrX,
   .tablePtr, .pushValid, .irqTake);
`default_nettype wire

// [crf_mem_model.sv]
// memory responder for external loads
`timescale 1ns/1ns
`default_nettype none
module crf_mem_model (
   input  wire logic        clk,             // clock
   input  wire logic        rst,             // reset
   input  wire logic        memRead,         // read pulse
   input  wire logic [15:0] memAddr,         // address
   output logic             loadReturnValid, // data pulse
   output logic [7:0]       loadReturnData   // data
);
   logic [2:0] waitCnt;
   // answers after 1 or 6 cycles, junk between answers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         waitCnt <= 3'h0;
         loadReturnValid <= 1'b0;
         loadReturnData <= 8'h00;
      end else begin
         loadReturnValid <= waitCnt == 3'h1;
         loadReturnData <= waitCnt == 3'h1 ? memAddr[7:0] + 8'h3C : ~loadReturnData;
         if (memRead)
            waitCnt <= memAddr[1:0] == 2'h0 ? 3'h1 : 3'h6;
         else if (waitCnt != 3'h0)
            waitCnt <= waitCnt - 3'h1;
      end
   end
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the core register file and status flags
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, v) begin check_count++; if ((e) !== (v)) begin mismatches++; \
   $display("MISMATCH %s exp %h got %h", n, e, v); end end
module tb;
   import crf_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, opValid = 1'b0, useImm = 1'b0, irqSlot = 1'b0;
   crf_op_e     opCode = OP_NOP;
   crf_addr_e   addrMode = ADDR_X;
   logic [4:0]  dstSel = 5'h00, srcSel = 5'h00, irqIndex;
   logic [2:0]  bitSel = 3'h0, b;
   logic [7:0]  immData = 8'h00, irqLines = 8'h00, st, statusFlags, loadReturnData, memWdata, g [32];
   logic [15:0] dataAddr = 16'h0000, programCounter = 16'h0000, ptrX, ptrY, tablePtr, memAddr, pushData;
   logic [15:0] qv [$], obs [9];
   logic        loadReturnValid, loadBusy, memRead, memWrite, pushValid, irqTake;
   int          mismatches = 0, check_count = 0, cyc = 0, idx, qs [$];
   string       nm [9] = '{"statusFlags", "ptrX", "ptrY", "tablePtr", "irqIndex", "pushData", "pushTake",
      "memAddr", "wrBusyData"};
   // 100 MHz clock
   always #5 clk = ~clk;
   crf_core #(.NUM_IRQ(8)) dut_u (.clk, .rst, .opValid, .opCode, .dstSel, .srcSel, .immData, .useImm, .bitSel,
      .addrMode, .dataAddr, .programCounter, .irqLines, .irqSlot, .loadReturnValid, .loadReturnData, .statusFlags,
      .ptrX, .ptrY, .tablePtr, .loadBusy, .memRead, .memWrite, .memAddr, .memWdata, .pushValid, .pushData,
      .irqTake, .irqIndex);
   crf_mem_model mdl_u (.clk, .rst, .memRead, .memAddr, .loadReturnValid, .loadReturnData);
   // results in note order; notes fall due at the next falling edge
   always_comb obs = '{{8'h00, statusFlags}, ptrX, ptrY, tablePtr, 16'(irqIndex), pushData,
      16'({pushValid, irqTake}), memAddr, {6'h00, memWrite, loadBusy, memWdata}};
   always @(negedge clk) begin
      while (qs.size() > 0) begin
         `CHK(nm[qs[0]], qv[0], obs[qs[0]])
         qs.delete(0);
         qv.delete(0);
      end
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic note(input int k, input logic [15:0] v);
      qs.push_back(k);
      qv.push_back(v);
   endtask
   // one operation, held for one taking edge
   task automatic op(input crf_op_e c, input logic [4:0] d, input logic [4:0] s, input logic [7:0] im);
      @(posedge clk);
      opValid <= 1'b1;
      opCode <= c;
      dstSel <= d;
      srcSel <= s;
      immData <= im;
      useImm <= c inside {OP_ADD, OP_ADC};
      @(posedge clk);
      opValid <= 1'b0;
   endtask
   // register plus constant, flags worked out here
   task automatic addi(input logic [4:0] d, input logic [7:0] im, input logic wc);
      logic [8:0] s;
      logic       h, v;
      s = g[d] + im + (wc & st[0]);
      h = {1'b0, g[d][3:0]} + im[3:0] + (wc & st[0]) > 5'h0F;
      v = g[d][7] == im[7] && s[7] != im[7];
      op(wc ? OP_ADC : OP_ADD, d, 5'h00, im);
      st = {st[7:6], h, s[7] ^ v, v, s[7], s[7:0] == 8'h00, s[8]};
      g[d] = s[7:0];
      note(0, {8'h00, st});
   endtask
   task automatic setr(input logic [4:0] d, input logic [7:0] v);
      addi(d, v - g[d], 1'b0);
   endtask
   initial begin
      void'($urandom(80464));
      st = 8'h00;
      foreach (g[i]) g[i] = 8'h00;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      note(0, 16'h0000);
      repeat (12) addi(5'(16 + $urandom % 4), 8'($urandom), 1'($urandom));
      setr(5'h1A, 8'h1C);
      setr(5'h1C, 8'($urandom));
      note(1, 16'h001C);
      op(OP_DATA_LOAD, 5'h1E, 5'h1E, 8'h00);
      note(3, {8'h00, g[28]});
      op(OP_MOVW, 5'h1E, 5'h1A, 8'h00);
      note(3, 16'h001C);
      b = 3'($urandom);
      bitSel <= b;
      op(OP_BIT_STORE, 5'h1C, 5'h1C, 8'h00);
      st[6] = g[28][b];
      note(0, {8'h00, st});
      bitSel <= ~b;
      op(OP_BIT_LOAD, 5'h1A, 5'h1A, 8'h00);
      g[26][~b] = st[6];
      note(1, {8'h00, g[26]});
      dataAddr <= 16'h003F;
      op(OP_IO_OUT, 5'h00, 5'h1A, 8'h00);
      st = g[26];
      note(0, {8'h00, st});
      addrMode <= ADDR_DIRECT;
      dataAddr <= 16'h005F;
      op(OP_DATA_LOAD, 5'h1C, 5'h1C, 8'h00);
      note(2, {8'h00, st});
      $display("test registers done");
      b = 3'($urandom);
      irqLines <= 8'h80 | (8'h01 << b);
      idx = b;
      programCounter <= 16'($urandom);
      op(OP_SET_GATE, 5'h00, 5'h00, 8'h00);
      irqSlot <= 1'b1;
      @(posedge clk);
      note(6, 16'h0003);
      note(4, 16'(idx));
      note(5, programCounter);
      note(0, {1'b0, st[6:0]});
      @(posedge clk);
      note(6, 16'h0000);
      op(OP_IRQ_RETURN, 5'h00, 5'h00, 8'h00);
      note(0, {1'b1, st[6:0]});
      op(OP_NOP, 5'h00, 5'h00, 8'h00);
      note(6, 16'h0000);
      @(posedge clk);
      note(6, 16'h0003);
      irqSlot <= 1'b0;
      op(OP_SET_GATE, 5'h00, 5'h00, 8'h00);
      note(0, {1'b1, st[6:0]});
      op(OP_CLEAR_GATE, 5'h00, 5'h00, 8'h00);
      st[7] = 1'b0;
      note(0, {8'h00, st});
      op(OP_CALL, 5'h00, 5'h00, 8'h00);
      note(6, 16'h0002);
      addrMode <= ADDR_X;
      for (int k = 0; k < 2; k++) begin
         setr(5'h1A, 8'(3 * k));
         setr(5'h1B, 8'h01);
         op(OP_DATA_LOAD, 5'h1C, 5'h1C, 8'h00);
         @(posedge clk);
         for (int i = 0; i < 20 && loadBusy !== 1'b0; i++) @(posedge clk);
         note(2, {8'h00, 8'(3 * k) + 8'h3C});
         note(7, {8'h01, 8'(3 * k)});
         note(8, 16'h0000);
      end
      addrMode <= ADDR_Y;
      op(OP_DATA_STORE, 5'h00, 5'h1B, 8'h00);
      note(7, 16'h003F);
      note(8, 16'h0201);
      $display("test gate and loads done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      note(0, 16'h0000);
      note(1, 16'h0000);
      note(3, 16'h0000);
      $display("test reset done");
      repeat (2) @(posedge clk);
      give_verdict();
   end
endmodule
`default_nettype wire
